// ==== hw/uafb_pkg.sv ====
// Constants for the two-channel FIFO data access port.
// Assumes a single bus clock and word-aligned memory requests from the host.
package uafb_pkg;
    localparam int ADDR_W = 12;
    localparam int NUM_CH = 2;
    localparam int DEPTH = 256;
    localparam int PTR_W = 9;
    localparam int IDX_W = 8;
    localparam logic [PTR_W-1:0] DEPTH_P = 9'h100;
    // Address field positions
    localparam int MAP_BIT = 11;
    localparam int CH_BIT = 10;
    localparam int PAGE_HI = 9;
    localparam int PAGE_LO = 8;
    // Page codes within a channel block
    localparam logic [1:0] PAGE_HOLD = 2'h0;
    localparam logic [1:0] PAGE_BULK = 2'h1;
    // Documented window offsets
    localparam logic [11:0] CH0_HOLD = 12'h000;
    localparam logic [11:0] CH0_BULK = 12'h100;
    localparam logic [11:0] CH0_STAT = 12'h200;
    localparam logic [11:0] CH1_HOLD = 12'h400;
    localparam logic [11:0] CH1_BULK = 12'h500;
    localparam logic [11:0] CH1_STAT = 12'h600;
    localparam logic [3:0] LANE0 = 4'h1;

    // Number of enabled lanes
    function automatic logic [2:0] uafb_popcnt(input logic [3:0] m);
        uafb_popcnt = {2'h0, m[0]} + {2'h0, m[1]} + {2'h0, m[2]} + {2'h0, m[3]};
    endfunction : uafb_popcnt

    // Ordinal of lane i among enabled lanes
    function automatic logic [2:0] uafb_rank(input logic [3:0] m, input int i);
        logic [3:0] below;
        below = m & ((4'h1 << i) - 4'h1);
        uafb_rank = uafb_popcnt(below);
    endfunction : uafb_rank
endpackage : uafb_pkg

// ==== hw/uafb_port.sv ====
// Host data access port moving bytes between memory requests and the
// per-channel TX and RX FIFOs of two UART channels.
// Assumes requests are word aligned, answered one cycle later, never stalled.
module uafb_port
    import uafb_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [uafb_pkg::ADDR_W-1:0] req_addr,
    input wire logic [3:0] req_be,
    input wire logic [31:0] req_wdata,
    output logic rsp_valid,
    output logic [31:0] rsp_rdata,
    input wire logic [1:0] rx_wr_valid,
    input wire logic [1:0][7:0] rx_wr_data,
    input wire logic [1:0][7:0] rx_wr_status,
    output logic [1:0] rx_wr_ready,
    output logic [1:0] tx_rd_valid,
    output logic [1:0][7:0] tx_rd_data,
    input wire logic [1:0] tx_rd_ready
);
    import uafb_pkg::*;

    // Storage: RX entries hold {data, line status}
    logic [7:0] tx_mem [NUM_CH][DEPTH];
    logic [15:0] rx_mem [NUM_CH][DEPTH];
    logic [PTR_W-1:0] tx_wr_ptr [NUM_CH];
    logic [PTR_W-1:0] tx_rd_ptr [NUM_CH];
    logic [PTR_W-1:0] rx_wr_ptr [NUM_CH];
    logic [PTR_W-1:0] rx_rd_ptr [NUM_CH];
    logic [PTR_W-1:0] tx_count [NUM_CH];
    logic [PTR_W-1:0] rx_count [NUM_CH];

    logic ch;
    logic [1:0] page;
    logic is_hold;
    logic is_bulk;
    logic is_stat;
    logic [3:0] tx_be;
    logic [3:0] rx_be;
    logic [3:0] half_en;
    logic [PTR_W-1:0] tx_free;
    logic [PTR_W-1:0] rx_avail;
    logic [3:0] tx_lane_we;
    logic [PTR_W-1:0] n_push;
    logic [PTR_W-1:0] n_pop;
    logic [31:0] next_rdata;

    // Occupancy per channel
    always_comb begin
        for (int c = 0; c < NUM_CH; c++) begin
            tx_count[c] = tx_wr_ptr[c] - tx_rd_ptr[c];
            rx_count[c] = rx_wr_ptr[c] - rx_rd_ptr[c];
        end
    end

    // Address decode into channel and window
    always_comb begin
        ch = req_addr[CH_BIT];
        page = req_addr[PAGE_HI:PAGE_LO];
        is_hold = !req_addr[MAP_BIT] && page == PAGE_HOLD && req_addr[7:2] == 6'h00;
        is_bulk = !req_addr[MAP_BIT] && page == PAGE_BULK;
        is_stat = !req_addr[MAP_BIT] && page[1];
    end

    // Lane masks; the holding path only ever uses lane 0
    always_comb begin
        tx_be = 4'h0;
        rx_be = 4'h0;
        if (req_valid && req_write) begin
            if (is_bulk) begin
                tx_be = req_be;
            end else if (is_hold) begin
                tx_be = req_be & LANE0;
            end
        end else if (req_valid) begin
            if (is_bulk) begin
                rx_be = req_be;
            end else if (is_hold) begin
                rx_be = req_be & LANE0;
            end
        end
        // Status window consumes one entry per touched half
        half_en = {2'h0, |req_be[3:2], |req_be[1:0]};
    end

    // Push and pop counts clipped to space and content
    always_comb begin
        tx_free = DEPTH_P - tx_count[ch];
        rx_avail = rx_count[ch];
        n_push = {6'h00, uafb_popcnt(tx_be)};
        if (n_push > tx_free) begin
            n_push = tx_free;
        end
        n_pop = 9'h000;
        if (req_valid && !req_write) begin
            if (is_stat) begin
                n_pop = {6'h00, uafb_popcnt(half_en)};
            end else begin
                n_pop = {6'h00, uafb_popcnt(rx_be)};
            end
        end
        if (n_pop > rx_avail) begin
            n_pop = rx_avail;
        end
        for (int i = 0; i < 4; i++) begin
            tx_lane_we[i] = tx_be[i] && ({6'h00, uafb_rank(tx_be, i)} < tx_free);
        end
    end

    // Read data: k-th enabled lane gets k-th oldest entry
    always_comb begin
        logic [15:0] ent;
        logic [2:0] r;
        ent = 16'h0000;
        r = 3'h0;
        next_rdata = 32'h0000_0000;
        for (int i = 0; i < 4; i++) begin
            r = uafb_rank(rx_be, i);
            ent = rx_mem[ch][rx_rd_ptr[ch][IDX_W-1:0] + {5'h00, r}];
            if (rx_be[i] && {6'h00, r} < rx_avail) begin
                next_rdata[8*i +: 8] = ent[15:8];
            end
        end
        if (req_valid && !req_write && is_stat) begin
            for (int j = 0; j < 2; j++) begin
                r = uafb_rank(half_en, j);
                ent = rx_mem[ch][rx_rd_ptr[ch][IDX_W-1:0] + {5'h00, r}];
                if (half_en[j] && {6'h00, r} < rx_avail) begin
                    next_rdata[16*j +: 16] = ent;
                end
            end
        end
    end

    // Answer one cycle after every request
    always_ff @(posedge clock) begin
        if (!rstn) begin
            rsp_valid <= 1'b0;
            rsp_rdata <= 32'h0000_0000;
        end else begin
            rsp_valid <= req_valid;
            rsp_rdata <= req_valid && !req_write ? next_rdata : 32'h0000_0000;
        end
    end

    // TX FIFO pointers: host fills, serial side drains
    always_ff @(posedge clock) begin
        if (!rstn) begin
            for (int c = 0; c < NUM_CH; c++) begin
                tx_wr_ptr[c] <= 9'h000;
                tx_rd_ptr[c] <= 9'h000;
            end
        end else begin
            for (int c = 0; c < NUM_CH; c++) begin
                if (c == int'(ch)) begin
                    tx_wr_ptr[c] <= tx_wr_ptr[c] + n_push;
                end
                if (tx_rd_valid[c] && tx_rd_ready[c]) begin
                    tx_rd_ptr[c] <= tx_rd_ptr[c] + 9'h001;
                end
            end
        end
    end

    // RX FIFO pointers: serial side fills, host drains
    always_ff @(posedge clock) begin
        if (!rstn) begin
            for (int c = 0; c < NUM_CH; c++) begin
                rx_wr_ptr[c] <= 9'h000;
                rx_rd_ptr[c] <= 9'h000;
            end
        end else begin
            for (int c = 0; c < NUM_CH; c++) begin
                if (rx_wr_valid[c] && rx_wr_ready[c]) begin
                    rx_wr_ptr[c] <= rx_wr_ptr[c] + 9'h001;
                end
                if (c == int'(ch)) begin
                    rx_rd_ptr[c] <= rx_rd_ptr[c] + n_pop;
                end
            end
        end
    end

    // FIFO storage writes, lane 0 at the oldest free slot
    always_ff @(posedge clock) begin
        for (int c = 0; c < NUM_CH; c++) begin
            for (int i = 0; i < 4; i++) begin
                if (c == int'(ch) && tx_lane_we[i]) begin
                    tx_mem[c][tx_wr_ptr[c][IDX_W-1:0] + {5'h00, uafb_rank(tx_be, i)}] <=
                        req_wdata[8*i +: 8];
                end
            end
            if (rx_wr_valid[c] && rx_wr_ready[c]) begin
                rx_mem[c][rx_wr_ptr[c][IDX_W-1:0]] <= {rx_wr_data[c], rx_wr_status[c]};
            end
        end
    end

    // Serial-side handshakes
    always_comb begin
        for (int c = 0; c < NUM_CH; c++) begin
            rx_wr_ready[c] = rx_count[c] != DEPTH_P;
            tx_rd_valid[c] = tx_count[c] != 9'h000;
            tx_rd_data[c] = tx_mem[c][tx_rd_ptr[c][IDX_W-1:0]];
        end
    end

    // Every request answered with rsp_valid next cycle
    property p_rsp_next;
        @(posedge clock) disable iff (!rstn)
        req_valid |=> rsp_valid;
    endproperty
    a_rsp_next: assert property (p_rsp_next) else $error("request not answered");

    // Full word bulk write pushes four bytes
    property p_bulk_push4;
        @(posedge clock) disable iff (!rstn)
        req_valid && req_write && req_addr == CH0_BULK && req_be == 4'hF
            && tx_count[0] <= 9'h0FC
        |=> tx_wr_ptr[0] == $past(tx_wr_ptr[0]) + 9'h004;
    endproperty
    a_bulk_push4: assert property (p_bulk_push4) else $error("bulk write pushed wrong count");

    // Lane 0 byte lands in the oldest free slot
    property p_tx_order;
        @(posedge clock) disable iff (!rstn)
        req_valid && req_write && req_addr == CH1_BULK && req_be == 4'hF
            && tx_count[1] <= 9'h0FC
        |=> tx_mem[1][$past(tx_wr_ptr[1][IDX_W-1:0])] == $past(req_wdata[7:0]);
    endproperty
    a_tx_order: assert property (p_tx_order) else $error("tx byte order wrong");

    // Bulk read returns oldest byte in lane 0
    property p_rx_order;
        @(posedge clock) disable iff (!rstn)
        req_valid && !req_write && req_addr == CH0_BULK && req_be == 4'hF
            && rx_count[0] >= 9'h004
        |=> rsp_rdata[7:0] == $past(rx_mem[0][rx_rd_ptr[0][IDX_W-1:0]][15:8])
            && rx_rd_ptr[0] == $past(rx_rd_ptr[0]) + 9'h004;
    endproperty
    a_rx_order: assert property (p_rx_order) else $error("bulk read order wrong");

    // Holding write pushes exactly one byte
    property p_hold_push;
        @(posedge clock) disable iff (!rstn)
        req_valid && req_write && req_addr == CH1_HOLD && req_be == 4'hF
            && tx_count[1] != DEPTH_P
        |=> tx_wr_ptr[1] == $past(tx_wr_ptr[1]) + 9'h001;
    endproperty
    a_hold_push: assert property (p_hold_push) else $error("holding write not one byte");

    // Holding read pops exactly one byte
    property p_hold_pop;
        @(posedge clock) disable iff (!rstn)
        req_valid && !req_write && req_addr == CH0_HOLD && req_be == 4'hF
            && rx_count[0] != 9'h000
        |=> rx_rd_ptr[0] == $past(rx_rd_ptr[0]) + 9'h001 && rsp_rdata[31:8] == 24'h000000;
    endproperty
    a_hold_pop: assert property (p_hold_pop) else $error("holding read not one byte");

    // Status window pairs status low, data high
    property p_stat_pair;
        @(posedge clock) disable iff (!rstn)
        req_valid && !req_write && req_addr == CH0_STAT && req_be == 4'hF
            && rx_count[0] >= 9'h002
        |=> rsp_rdata[15:0] == $past(rx_mem[0][rx_rd_ptr[0][IDX_W-1:0]])
            && rx_rd_ptr[0] == $past(rx_rd_ptr[0]) + 9'h002;
    endproperty
    a_stat_pair: assert property (p_stat_pair) else $error("status pairing wrong");

    // Sparse lanes push only enabled bytes
    property p_sparse;
        @(posedge clock) disable iff (!rstn)
        req_valid && req_write && req_addr == CH0_BULK && req_be == 4'h5
            && tx_count[0] <= 9'h0FE
        |=> tx_wr_ptr[0] == $past(tx_wr_ptr[0]) + 9'h002
            && tx_mem[0][$past(tx_wr_ptr[0][IDX_W-1:0]) + 8'h01] == $past(req_wdata[23:16]);
    endproperty
    a_sparse: assert property (p_sparse) else $error("sparse lane push wrong");

    // Full TX FIFO ignores pushes
    property p_full;
        @(posedge clock) disable iff (!rstn)
        req_valid && req_write && req_addr == CH1_BULK && tx_count[1] == DEPTH_P
        |=> tx_wr_ptr[1] == $past(tx_wr_ptr[1]);
    endproperty
    a_full: assert property (p_full) else $error("push into full fifo moved pointer");

    // Channel 1 occupancy never exceeds depth
    property p_depth;
        @(posedge clock) disable iff (!rstn)
        tx_count[1] <= DEPTH_P && rx_count[1] <= DEPTH_P;
    endproperty
    a_depth: assert property (p_depth) else $error("fifo overfilled");

    // Channel 1 bulk read returns four bytes, newest in the top lane
    property p_bulk_rd1;
        @(posedge clock) disable iff (!rstn)
        req_valid && !req_write && req_addr == CH1_BULK && req_be == 4'hF
            && rx_count[1] >= 9'h004
        |=> rsp_rdata[31:24] == $past(rx_mem[1][rx_rd_ptr[1][IDX_W-1:0] + 8'h03][15:8])
            && rx_rd_ptr[1] == $past(rx_rd_ptr[1]) + 9'h004;
    endproperty
    a_bulk_rd1: assert property (p_bulk_rd1) else $error("channel 1 bulk read wrong");

    // Half-word bulk read pops two bytes and leaves upper lanes clear
    property p_bulk_half;
        @(posedge clock) disable iff (!rstn)
        req_valid && !req_write && req_addr[11:8] == CH0_BULK[11:8] && req_be == 4'h3
            && rx_count[0] >= 9'h002
        |=> rx_rd_ptr[0] == $past(rx_rd_ptr[0]) + 9'h002 && rsp_rdata[31:16] == 16'h0000;
    endproperty
    a_bulk_half: assert property (p_bulk_half) else $error("partial bulk read wrong");

    // Channel 1 status window pairs two entries per word
    property p_stat_ch1;
        @(posedge clock) disable iff (!rstn)
        req_valid && !req_write && req_addr == CH1_STAT && req_be == 4'hF
            && rx_count[1] >= 9'h002
        |=> rsp_rdata == {$past(rx_mem[1][rx_rd_ptr[1][IDX_W-1:0] + 8'h01]),
            $past(rx_mem[1][rx_rd_ptr[1][IDX_W-1:0]])};
    endproperty
    a_stat_ch1: assert property (p_stat_ch1) else $error("channel 1 status window wrong");

    // Writes to the status window push nothing
    property p_stat_nowrite;
        @(posedge clock) disable iff (!rstn)
        req_valid && req_write && req_addr == CH0_STAT
        |=> tx_wr_ptr[0] == $past(tx_wr_ptr[0]);
    endproperty
    a_stat_nowrite: assert property (p_stat_nowrite) else $error("status write pushed");

    // Unmapped reads answer zero and pop nothing
    property p_unmapped;
        @(posedge clock) disable iff (!rstn)
        req_valid && !req_write && req_addr[MAP_BIT]
        |=> rsp_rdata == 32'h0000_0000 && rx_rd_ptr[0] == $past(rx_rd_ptr[0])
            && rx_rd_ptr[1] == $past(rx_rd_ptr[1]);
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read had effect");

    // Read of an empty RX FIFO leaves its pointer alone
    property p_empty;
        @(posedge clock) disable iff (!rstn)
        req_valid && !req_write && req_addr == CH0_BULK && rx_count[0] == 9'h000
        |=> rx_rd_ptr[0] == $past(rx_rd_ptr[0]);
    endproperty
    a_empty: assert property (p_empty) else $error("pop from empty fifo moved pointer");

    // Channel 0 holding write pushes lane 0 only
    property p_hold0;
        @(posedge clock) disable iff (!rstn)
        req_valid && req_write && req_addr == CH0_HOLD && req_be == 4'hF
            && tx_count[0] != DEPTH_P
        |=> tx_wr_ptr[0] == $past(tx_wr_ptr[0]) + 9'h001
            && tx_mem[0][$past(tx_wr_ptr[0][IDX_W-1:0])] == $past(req_wdata[7:0]);
    endproperty
    a_hold0: assert property (p_hold0) else $error("channel 0 holding write wrong");
endmodule : uafb_port

// ==== sim/uafb_serial_model.sv ====
// Serial-side model: feeds RX bytes with their status, drains TX bytes.
// Assumes the port's RX ready and TX valid are settled before each edge.
module uafb_serial_model (
    input wire logic clock,
    output logic [1:0] rx_wr_valid,
    output logic [1:0][7:0] rx_wr_data,
    output logic [1:0][7:0] rx_wr_status,
    input wire logic [1:0] rx_wr_ready,
    input wire logic [1:0] tx_rd_valid,
    input wire logic [1:0][7:0] tx_rd_data,
    output logic [1:0] tx_rd_ready,
    input wire logic [1:0] sink_en
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] rxq [2][$];
    logic [7:0] txq [2][$];
    // Quiet outputs at time zero
    initial begin
        rx_wr_valid = 2'h0;
        rx_wr_data = 16'h0000;
        rx_wr_status = 16'h0000;
        tx_rd_ready = 2'h0;
    end
    // Offer queued RX entries, collect TX bytes while the sink is open
    always @(posedge clock) begin
        for (int c = 0; c < 2; c++) begin
            if (rx_wr_valid[c] && rx_wr_ready[c]) begin
                void'(rxq[c].pop_front());
            end
            if (tx_rd_valid[c] && tx_rd_ready[c]) begin
                txq[c].push_back(tx_rd_data[c]);
            end
            rx_wr_valid[c] <= rxq[c].size() > 0;
            // Idle lines toggle so a stale byte is never mistaken for data
            {rx_wr_data[c], rx_wr_status[c]} <= (rxq[c].size() > 0) ? rxq[c][0] :
                ~{rx_wr_data[c], rx_wr_status[c]};
            tx_rd_ready[c] <= sink_en[c];
        end
    end
endmodule : uafb_serial_model

// ==== sim/uart_fifo_bulk_access_port_tb.sv ====
// Testbench for the FIFO data access port: host bus tasks and scenarios.
// Assumes the serial model answers at once unless its sink is held off.
module uart_fifo_bulk_access_port_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0, rstn = 1'b0, req_valid = 1'b0, req_write = 1'b0, rsp_valid;
    logic [11:0] req_addr = 12'h000;
    logic [3:0] req_be = 4'h0;
    logic [31:0] req_wdata = 32'h0, rsp_rdata, q;
    logic [1:0] rx_wr_valid, rx_wr_ready, tx_rd_valid, tx_rd_ready, sink_en = 2'h0;
    logic [1:0][7:0] rx_wr_data, rx_wr_status, tx_rd_data;
    int miscompares = 0, checks_done = 0, cycles = 0;
    always #4 clock = ~clock;
    uafb_port dut_u (.clock, .rstn, .req_valid, .req_write, .req_addr, .req_be,
        .req_wdata, .rsp_valid, .rsp_rdata, .rx_wr_valid, .rx_wr_data, .rx_wr_status,
        .rx_wr_ready, .tx_rd_valid, .tx_rd_data, .tx_rd_ready);
    uafb_serial_model model_u (.clock, .rx_wr_valid, .rx_wr_data, .rx_wr_status,
        .rx_wr_ready, .tx_rd_valid, .tx_rd_data, .tx_rd_ready, .sink_en);
    // Compare and count
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", what, exp, got);
            miscompares++;
        end
    endtask : chk
    // One host request, answer taken on the falling edge after it is accepted
    task automatic bus(input logic w, input logic [11:0] a, input logic [3:0] be,
        input logic [31:0] d);
        @(posedge clock);
        req_valid <= 1'b1;
        req_write <= w;
        req_addr <= a;
        req_be <= be;
        req_wdata <= d;
        @(posedge clock);
        req_valid <= 1'b0;
        @(negedge clock);
        chk("rsp_valid", 32'h1, {31'h0, rsp_valid});
        q = rsp_rdata;
    endtask : bus
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : final_report
    // Bulk, sparse-lane and holding writes, plus refused writes
    task automatic t_tx();
        logic [7:0] e0 [7] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'hAA, 8'hCC, 8'h55};
        bus(1'b1, 12'h100, 4'hF, 32'h44332211);
        bus(1'b1, 12'h100, 4'h5, 32'h00CC00AA);
        bus(1'b1, 12'h000, 4'hF, 32'h99887755);
        bus(1'b1, 12'h200, 4'hF, 32'h76543210);
        bus(1'b1, 12'h900, 4'hF, 32'h76543210);
        bus(1'b1, 12'h500, 4'hF, 32'h0D0C0B0A);
        bus(1'b1, 12'h400, 4'hF, 32'hDDCCBBEE);
        sink_en <= 2'h3;
        for (int i = 0; i < 50 && tx_rd_valid !== 2'h0; i++) @(negedge clock);
        sink_en <= 2'h0;
        chk("tx0 count", 7, model_u.txq[0].size());
        for (int i = 0; i < 7; i++) chk("tx0 byte", e0[i], model_u.txq[0][i]);
        chk("tx1 count", 5, model_u.txq[1].size());
        for (int i = 0; i < 4; i++) chk("tx1 byte", 8'h0A + i, model_u.txq[1][i]);
        chk("tx1 holding", 8'hEE, model_u.txq[1][4]);
        model_u.txq[1].delete();
        $display("t_tx done");
    endtask : t_tx
    // Bulk, partial, holding, status-paired and empty reads
    task automatic t_rx();
        for (int i = 0; i < 9; i++) model_u.rxq[0].push_back(16'h1040 + 16'(i * 257));
        for (int i = 1; i < 7; i++) model_u.rxq[1].push_back(16'hA0B0 + 16'(i * 257));
        // Wait until the model has handed every queued entry to the port
        for (int i = 0; i < 30 && model_u.rxq[0].size() + model_u.rxq[1].size() > 0; i++)
            @(negedge clock);
        bus(1'b0, 12'h100, 4'hF, 32'h0);
        chk("bulk rx", 32'h13121110, q);
        bus(1'b0, 12'h1FC, 4'h3, 32'h0);
        chk("bulk rx 16", 32'h00001514, q);
        bus(1'b0, 12'h000, 4'hF, 32'h0);
        chk("holding rx", 32'h00000016, q);
        bus(1'b0, 12'h200, 4'hF, 32'h0);
        chk("status rx", 32'h18481747, q);
        bus(1'b0, 12'h100, 4'hF, 32'h0);
        chk("empty rx", 32'h0, q);
        bus(1'b0, 12'h600, 4'hF, 32'h0);
        chk("status rx1", 32'hA2B2A1B1, q);
        bus(1'b0, 12'h500, 4'hF, 32'h0);
        chk("bulk rx1", 32'hA6A5A4A3, q);
        bus(1'b0, 12'h800, 4'hF, 32'h0);
        chk("unmapped", 32'h0, q);
        $display("t_rx done");
    endtask : t_rx
    // Overfill TX and RX FIFOs, then drain both
    task automatic t_full();
        for (int i = 0; i < 65; i++) bus(1'b1, 12'h500, 4'hF, 32'h03020100 + 32'(i * 32'h04040404));
        sink_en <= 2'h2;
        for (int i = 0; i < 400 && tx_rd_valid[1] === 1'b1; i++) @(negedge clock);
        sink_en <= 2'h0;
        chk("tx1 full count", 256, model_u.txq[1].size());
        chk("tx1 last", 8'hFF, model_u.txq[1][255]);
        for (int i = 0; i < 257; i++) model_u.rxq[0].push_back({i[7:0], 8'h5A});
        for (int i = 0; i < 400 && rx_wr_ready[0] === 1'b1; i++) @(negedge clock);
        chk("rx0 left", 1, model_u.rxq[0].size());
        for (int i = 0; i < 64; i++) begin
            bus(1'b0, 12'h100, 4'hF, 32'h0);
            chk("rx0 drain", 32'h03020100 + 32'(i * 32'h04040404), q);
        end
        repeat (3) @(negedge clock);
        bus(1'b0, 12'h200, 4'h3, 32'h0);
        chk("rx0 late", 32'h0000005A, q);
        $display("t_full done");
    endtask : t_full
    // Hang guard
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            final_report();
        end
    end
    // Main sequence
    initial begin
        repeat (2) @(posedge clock);
        rstn <= 1'b1;
        t_tx();
        t_rx();
        t_full();
        final_report();
    end
endmodule : uart_fifo_bulk_access_port_tb
